/* hw/pp_device.sv */
// Purpose: device end of the parallel programming port
// Assumes: pins synchronous to clk_in
// Notes: busy held 4 ms for writes, 8 ms for erase
// Summary of operation
// - load select picks command, address or data
// - byte select picks address byte; values kept
// - write strobe low starts operation, busy low
// - command 02 reads flash, high address 0-3
// - flash read: byte select picks byte
// - command 03 reads eeprom by low address
// - command 40 writes fuses, 0 programs
// - both selects low writes low fuses
// - first select high writes high fuses
// - command 20 programs lock bits where 0
// - only chip erase or reset clears lock bits
// - command 04 reads fuses and lock bits
// - command 08 reads signature byte 0-2
// - command 08 with select high reads calibration
// - busy within 1 us, 3.7-4.5 ms writes
// - chip erase busy 7.5-9 ms
// - chip erase leaves memories all ff
`timescale 1ns/1ns
`include "pp_params.svh"
module pp_device #(
  parameter int WRITE_CYC = `PP_WRITE_CYC,
  parameter int ERASE_CYC = `PP_ERASE_CYC,
  parameter int FLASH_WORDS = 1024,
  parameter int EE_BYTES = 128,
  parameter logic [7:0] SIG0 = 8'h5a, // arbitrary value
  parameter logic [7:0] SIG1 = 8'h11, // arbitrary value
  parameter logic [7:0] SIG2 = 8'h22, // arbitrary value
  parameter logic [7:0] CALIB = 8'h80
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  pp_if.device pins,
  output pp_pkg::byte_type lock_bits_out
);
  import pp_pkg::*;
  // signature values arbitrary
  localparam int CW = $clog2(ERASE_CYC + 1);
  byte_type cmd_r, addr_lo_r, addr_hi_r, data_lo_r, data_hi_r;
  byte_type fuse_lo_r, fuse_hi_r, lock_r;
  logic [15:0] flash_mem [FLASH_WORDS];
  byte_type ee_mem [EE_BYTES];
  prog_state_type state_r;
  logic [CW-1:0] cnt_r;
  logic strobe_d_r, wr_d_r;
  logic [7:0] dout_r;
  logic doe_r;
  logic rdy_r;
  byte_type op_cmd_r;
  logic op_bsa_r;

  wire strobe_rise = pins.load_strobe_pin & ~strobe_d_r;
  wire wr_fall = ~pins.wr_b & wr_d_r;
  wire [1:0] lsel = {pins.load_select_hi, pins.load_select_lo};
  wire [7:0] addr_hi_lim = addr_hi_r & `PP_FLASH_HI_MASK;
  wire [9:0] flash_addr = {addr_hi_lim[1:0], addr_lo_r};
  wire [6:0] ee_addr = addr_lo_r[6:0];
  wire [15:0] flash_word = flash_mem[flash_addr[$clog2(FLASH_WORDS)-1:0]];
  wire op_is_write = cmd_r == `PP_CMD_WFLASH || cmd_r == `PP_CMD_WEE ||
    cmd_r == `PP_CMD_WFUSE || cmd_r == `PP_CMD_WLOCK;
  wire op_is_erase = cmd_r == `PP_CMD_ERASE;
  wire start_op = wr_fall && state_r == ST_IDLE && (op_is_write || op_is_erase);

  function automatic byte_type sig_sel(input byte_type a);
    case (a)
      8'h00: sig_sel = SIG0;
      8'h01: sig_sel = SIG1;
      `PP_SIG_LAST: sig_sel = SIG2;
      default: sig_sel = 8'h00;
    endcase
  endfunction

  logic [7:0] read_val;
  always_comb begin
    read_val = 8'h00;
    case (cmd_r)
      `PP_CMD_RFLASH: read_val = pins.byte_select_a ? flash_word[15:8] : flash_word[7:0];
      `PP_CMD_REE: read_val = pins.byte_select_a ? 8'h00 : ee_mem[ee_addr];
      `PP_CMD_RFUSE: begin
        if (!pins.byte_select_a && !pins.byte_select_b) read_val = fuse_lo_r;
        else if (pins.byte_select_a && pins.byte_select_b) read_val = fuse_hi_r;
        else if (pins.byte_select_a) read_val = lock_r;
      end
      `PP_CMD_RSIG: read_val = pins.byte_select_a ? CALIB : sig_sel(addr_lo_r);
      default: read_val = 8'h00;
    endcase
  end

  // latch registers on load strobe; ignored while busy
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cmd_r <= 8'h00;
      addr_lo_r <= 8'h00;
      addr_hi_r <= 8'h00;
      data_lo_r <= 8'h00;
      data_hi_r <= 8'h00;
      strobe_d_r <= 1'b0;
      wr_d_r <= 1'b1;
    end else begin
      strobe_d_r <= pins.load_strobe_pin;
      wr_d_r <= pins.wr_b;
      if (strobe_rise && state_r == ST_IDLE) begin
        case (lsel)
          `PP_LS_CMD: cmd_r <= pins.prog_data;
          `PP_LS_ADDR: begin
            if (pins.byte_select_a) addr_hi_r <= pins.prog_data;
            else addr_lo_r <= pins.prog_data;
          end
          `PP_LS_DATA: begin
            if (pins.byte_select_a) data_hi_r <= pins.prog_data;
            else data_lo_r <= pins.prog_data;
          end
          default: ;
        endcase
      end
    end
  end

  // busy timer; effect applied when done, like the real cell
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      rdy_r <= 1'b1;
      op_cmd_r <= 8'h00;
      op_bsa_r <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: if (start_op) begin
          state_r <= ST_BUSY;
          rdy_r <= 1'b0;
          op_cmd_r <= cmd_r;
          op_bsa_r <= pins.byte_select_a;
          cnt_r <= op_is_erase ? CW'(ERASE_CYC - 1) : CW'(WRITE_CYC - 1);
        end
        ST_BUSY: if (cnt_r == '0) state_r <= ST_DONE;
          else cnt_r <= cnt_r - 1'b1;
        ST_DONE: begin
          state_r <= ST_IDLE;
          rdy_r <= 1'b1;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // fuse and lock bit updates at end of operation
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fuse_lo_r <= `PP_FUSE_LO_RESET;
      fuse_hi_r <= `PP_FUSE_HI_RESET;
      lock_r <= `PP_LOCK_RESET;
    end else if (state_r == ST_DONE) begin
      case (op_cmd_r)
        `PP_CMD_WFUSE: if (op_bsa_r) fuse_hi_r <= data_lo_r;
          else fuse_lo_r <= data_lo_r;
        `PP_CMD_WLOCK: lock_r <= lock_r & data_lo_r;
        `PP_CMD_ERASE: lock_r <= `PP_LOCK_RESET;
        default: ;
      endcase
    end
  end

  // arrays not reset; erase rewrites them
  always_ff @(posedge clk_in) begin
    if (state_r == ST_DONE) begin
      if (op_cmd_r == `PP_CMD_ERASE) begin
        for (int i = 0; i < FLASH_WORDS; i++) flash_mem[i] <= {`PP_ERASED, `PP_ERASED};
        for (int j = 0; j < EE_BYTES; j++) ee_mem[j] <= `PP_ERASED;
      end else if (op_cmd_r == `PP_CMD_WFLASH) begin
        flash_mem[flash_addr[$clog2(FLASH_WORDS)-1:0]] <= {data_hi_r, data_lo_r};
      end else if (op_cmd_r == `PP_CMD_WEE) begin
        ee_mem[ee_addr] <= data_lo_r;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dout_r <= 8'h00;
      doe_r <= 1'b0;
    end else begin
      doe_r <= ~pins.oe_b;
      dout_r <= pins.oe_b ? 8'h00 : read_val;
    end
  end

  assign pins.dev_data = dout_r;
  assign pins.dev_data_oe = doe_r;
  assign pins.ready_not_busy = rdy_r;
  assign lock_bits_out = lock_r;
endmodule

/* hw/pp_params.svh */
// Purpose: constants for the parallel programming port
// Assumes: 100 MHz system clock
// Notes: times in ns or us, cycle counts derived
`ifndef PP_PARAMS_SVH
`define PP_PARAMS_SVH
`define PP_CLK_NS 10
`define PP_LS_CMD 2'b10
`define PP_LS_ADDR 2'b00
`define PP_LS_DATA 2'b01
`define PP_CMD_ERASE 8'h80
`define PP_CMD_WFUSE 8'h40
`define PP_CMD_WLOCK 8'h20
`define PP_CMD_WFLASH 8'h10
`define PP_CMD_WEE 8'h11
`define PP_CMD_RSIG 8'h08
`define PP_CMD_RFUSE 8'h04
`define PP_CMD_RFLASH 8'h02
`define PP_CMD_REE 8'h03
`define PP_ERASED 8'hff
`define PP_FLASH_HI_MASK 8'h03
`define PP_SIG_LAST 8'h02
`define PP_LOCK_RESET 8'hff
`define PP_FUSE_LO_RESET 8'hff
`define PP_FUSE_HI_RESET 8'hff
`define PP_WRITE_US 4000
`define PP_ERASE_US 8000
`define PP_WRITE_CYC (`PP_WRITE_US * 1000 / `PP_CLK_NS)
`define PP_ERASE_CYC (`PP_ERASE_US * 1000 / `PP_CLK_NS)
`endif

/* hw/pp_pkg.sv */
// Purpose: shared types for the parallel programming port
// Assumes: nothing
// Notes: none
package pp_pkg;
  typedef logic [7:0] byte_type;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BUSY = 3'b010,
    ST_DONE = 3'b100
  } prog_state_type;
endpackage

/* hw/pp_if.sv */
// Purpose: pins between programmer and device
// Assumes: data bus resolved here from enables
// Notes: none
`timescale 1ns/1ns
interface pp_if;
  logic load_strobe_pin;
  logic load_select_hi;
  logic load_select_lo;
  logic byte_select_a;
  logic byte_select_b;
  logic wr_b;
  logic oe_b;
  logic ready_not_busy;
  logic [7:0] prog_data;
  logic prog_data_oe;
  logic [7:0] dev_data;
  logic dev_data_oe;
  wire [7:0] bus = dev_data_oe ? dev_data : (prog_data_oe ? prog_data : 8'h00);
  modport device (input load_strobe_pin, load_select_hi, load_select_lo, byte_select_a, byte_select_b,
    wr_b, oe_b, prog_data, prog_data_oe, output ready_not_busy, dev_data, dev_data_oe);
  modport programmer (output load_strobe_pin, load_select_hi, load_select_lo, byte_select_a, byte_select_b,
    wr_b, oe_b, prog_data, prog_data_oe, input ready_not_busy, dev_data, dev_data_oe, bus);
endinterface

/* hw/pp_programmer.sv */
// Purpose: programmer end driving strobes and bus
// Assumes: user issues one request at a time
// Notes: req kinds: 0 cmd, 1 addr, 2 data, 3 write, 4 read
`timescale 1ns/1ns
`include "pp_params.svh"
module pp_programmer #(
  parameter int PULSE_CYC = 20
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  pp_if.programmer pins,
  input wire logic req_in,
  input wire logic [2:0] kind_in,
  input wire logic bsa_in,
  input wire logic bsb_in,
  input wire logic [7:0] data_in,
  output logic busy_out,
  output logic done_out,
  output pp_pkg::byte_type rdata_out
);
  import pp_pkg::*;
  localparam int PW = $clog2(PULSE_CYC + 1);
  prog_state_type st_r;
  logic [PW-1:0] cnt_r;
  logic [2:0] kind_r;
  logic strobe_r, wr_r, oe_r, bsa_r, bsb_r, hi_r, lo_r, pdoe_r, busy_r, done_r;
  byte_type pd_r, rdata_r;
  wire waiting_rdy = kind_r == 3'h3;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r <= ST_IDLE;
      cnt_r <= '0;
      kind_r <= 3'h0;
      {strobe_r, oe_r, bsa_r, bsb_r, hi_r, lo_r, pdoe_r, busy_r, done_r} <= '0;
      wr_r <= 1'b1;
      pd_r <= 8'h00;
      rdata_r <= 8'h00;
    end else begin
      done_r <= 1'b0;
      case (st_r)
        ST_IDLE: if (req_in) begin
          st_r <= ST_BUSY;
          busy_r <= 1'b1;
          kind_r <= kind_in;
          cnt_r <= PW'(PULSE_CYC);
          bsa_r <= bsa_in;
          bsb_r <= bsb_in;
          pd_r <= data_in;
          {hi_r, lo_r} <= kind_in == 3'h0 ? `PP_LS_CMD : (kind_in == 3'h1 ? `PP_LS_ADDR : `PP_LS_DATA);
          pdoe_r <= kind_in < 3'h3;
          oe_r <= kind_in == 3'h4;
        end
        ST_BUSY: begin
          cnt_r <= cnt_r - 1'b1;
          if (cnt_r == PW'(PULSE_CYC - 2)) begin
            strobe_r <= kind_r < 3'h3;
            wr_r <= ~(kind_r == 3'h3);
          end
          if (cnt_r == '0) begin
            strobe_r <= 1'b0;
            wr_r <= 1'b1;
            rdata_r <= pins.bus;
            st_r <= ST_DONE;
          end
        end
        ST_DONE: if (!waiting_rdy || pins.ready_not_busy) begin
          st_r <= ST_IDLE;
          busy_r <= 1'b0;
          done_r <= 1'b1;
          oe_r <= 1'b0;
          pdoe_r <= 1'b0;
          bsa_r <= 1'b0;
          bsb_r <= 1'b0;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end
  assign pins.load_strobe_pin = strobe_r;
  assign pins.load_select_hi = hi_r;
  assign pins.load_select_lo = lo_r;
  assign pins.byte_select_a = bsa_r;
  assign pins.byte_select_b = bsb_r;
  assign pins.wr_b = wr_r;
  assign pins.oe_b = ~oe_r;
  assign pins.prog_data = pd_r;
  assign pins.prog_data_oe = pdoe_r;
  assign busy_out = busy_r;
  assign done_out = done_r;
  assign rdata_out = rdata_r;
endmodule

/* tb/pp_assertions.sv */
// Purpose: protocol checks on the programming pins
// Assumes: cycle counts scaled down as in the bench
// Notes: command tracked from load strobes, not from the device
`timescale 1ns/1ns
`include "pp_params.svh"
module pp_checker #(
  parameter int WRITE_CYC = `PP_WRITE_CYC,
  parameter int ERASE_CYC = `PP_ERASE_CYC,
  parameter logic [7:0] CALIB = 8'h80
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic load_strobe_pin,
  input wire logic load_select_hi,
  input wire logic load_select_lo,
  input wire logic byte_select_a,
  input wire logic byte_select_b,
  input wire logic wr_b,
  input wire logic oe_b,
  input wire logic ready_not_busy,
  input wire logic [7:0] prog_data,
  input wire logic prog_data_oe,
  input wire logic [7:0] dev_data,
  input wire logic dev_data_oe
);
  logic [7:0] cmd_r;
  logic [7:0] cmd_nxt;
  int busy_r;
  int busy_nxt;
  // level latch is enough: the bus is held for the whole strobe
  wire take_cmd = load_strobe_pin && load_select_hi && !load_select_lo && ready_not_busy;
  wire is_erase = cmd_r == `PP_CMD_ERASE;
  wire is_wr = cmd_r inside {`PP_CMD_ERASE, `PP_CMD_WFUSE, `PP_CMD_WLOCK, `PP_CMD_WFLASH, `PP_CMD_WEE};
  assign cmd_nxt = take_cmd ? prog_data : cmd_r;
  assign busy_nxt = ready_not_busy ? 0 : busy_r + 1;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cmd_r <= 8'h00;
      busy_r <= 0;
    end else begin
      cmd_r <= cmd_nxt;
      busy_r <= busy_nxt;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  chk_oe_release: assert property (oe_b [*2] |-> !dev_data_oe) else $error("bus driven with oe high");
  chk_oe_drive: assert property (!oe_b [*3] |-> dev_data_oe) else $error("bus not driven with oe low");
  chk_busy_start: assert property ($fell(wr_b) && ready_not_busy && is_wr |-> ##[1:3] !ready_not_busy)
    else $error("busy not raised after write strobe");
  chk_write_span: assert property ($rose(ready_not_busy) && !is_erase |->
    busy_r >= WRITE_CYC * 37 / 40 && busy_r <= WRITE_CYC * 9 / 8) else $error("write busy span off");
  chk_erase_span: assert property ($rose(ready_not_busy) && is_erase |->
    busy_r >= ERASE_CYC * 15 / 16 && busy_r <= ERASE_CYC * 9 / 8) else $error("erase busy span off");
  chk_calib_byte: assert property (cmd_r == `PP_CMD_RSIG && byte_select_a && !oe_b && !$past(oe_b)
    && $past(byte_select_a) |-> dev_data == CALIB) else $error("calibration byte wrong");
  chk_wait_ready: assert property (!ready_not_busy |-> !load_strobe_pin) else $error("load while busy");
  chk_strobe_bus: assert property (load_strobe_pin && $past(load_strobe_pin) |-> prog_data_oe
    && $stable({load_select_hi, load_select_lo, prog_data})) else $error("load inputs moved in strobe");
  chk_sel_hold: assert property (!wr_b |-> $stable({byte_select_a, byte_select_b}))
    else $error("select moved in write");
endmodule

/* tb/parallel_prog_read_fuse_lock_bench.sv */
// Purpose: programmer and device joined, driven from the user side
// Assumes: write and erase spans scaled to 50 and 100 cycles
// Notes: memories undefined until the first erase
`timescale 1ns/1ns
`include "pp_params.svh"
module parallel_prog_read_fuse_lock_bench;
  import pp_pkg::*;
  localparam int WC = 50;
  localparam int EC = 100;
  localparam logic [7:0] CAL = 8'h3e; // arbitrary value
  localparam logic [7:0] SIGS [3] = '{8'h1e, 8'h2d, 8'h4b}; // arbitrary values
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic req_in = 1'b0;
  logic [2:0] kind_in = 3'h0;
  logic bsa_in = 1'b0;
  logic bsb_in = 1'b0;
  logic [7:0] data_in = 8'h00;
  logic busy_out;
  logic done_out;
  byte_type rdata_out;
  byte_type lock_bits_out;
  int n_mismatch = 0;
  int n_checks = 0;
  pp_if pins();
  pp_device #(.WRITE_CYC(WC), .ERASE_CYC(EC), .SIG0(SIGS[0]), .SIG1(SIGS[1]), .SIG2(SIGS[2]), .CALIB(CAL))
    u_pp_device (.clk_in(clk_in), .rst_b_in(rst_b_in), .pins(pins.device), .lock_bits_out(lock_bits_out));
  pp_programmer u_pp_programmer (.clk_in(clk_in), .rst_b_in(rst_b_in), .pins(pins.programmer), .req_in(req_in),
    .kind_in(kind_in), .bsa_in(bsa_in), .bsb_in(bsb_in), .data_in(data_in), .busy_out(busy_out),
    .done_out(done_out), .rdata_out(rdata_out));
  pp_checker #(.WRITE_CYC(WC), .ERASE_CYC(EC), .CALIB(CAL)) u_pp_checker (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .load_strobe_pin(pins.load_strobe_pin), .load_select_hi(pins.load_select_hi),
    .load_select_lo(pins.load_select_lo), .byte_select_a(pins.byte_select_a),
    .byte_select_b(pins.byte_select_b), .wr_b(pins.wr_b), .oe_b(pins.oe_b),
    .ready_not_busy(pins.ready_not_busy), .prog_data(pins.prog_data), .prog_data_oe(pins.prog_data_oe),
    .dev_data(pins.dev_data), .dev_data_oe(pins.dev_data_oe));
  always #5 clk_in = ~clk_in;
  task automatic cmp(input byte_type got, input byte_type exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic op(input logic [2:0] k, input logic a, input logic b, input byte_type d);
    int i;
    @(posedge clk_in);
    #1;
    kind_in = k;
    bsa_in = a;
    bsb_in = b;
    data_in = d;
    req_in = 1'b1;
    @(posedge clk_in);
    #1;
    req_in = 1'b0;
    cmp({7'h00, busy_out}, 8'h01);
    i = 0;
    // longest op is an erase, well under this bound
    while (done_out !== 1'b1 && i < 400) begin
      @(posedge clk_in);
      #1;
      i++;
    end
    cmp({7'h00, done_out}, 8'h01);
    cmp({7'h00, busy_out}, 8'h00);
  endtask
  task automatic rd(input logic a, input logic b, input byte_type exp);
    op(3'h4, a, b, 8'h00);
    cmp(rdata_out, exp);
  endtask
  task automatic t_erase;
    op(3'h0, 1'b0, 1'b0, `PP_CMD_ERASE);
    op(3'h3, 1'b0, 1'b0, 8'h00);
    op(3'h0, 1'b0, 1'b0, `PP_CMD_RFLASH);
    op(3'h1, 1'b1, 1'b0, `PP_FLASH_HI_MASK);
    op(3'h1, 1'b0, 1'b0, 8'hff);
    rd(1'b0, 1'b0, `PP_ERASED);
    rd(1'b1, 1'b0, `PP_ERASED);
    op(3'h0, 1'b0, 1'b0, `PP_CMD_REE);
    rd(1'b0, 1'b0, `PP_ERASED);
    $display("test erase done");
  endtask
  task automatic t_flash_ee;
    op(3'h0, 1'b0, 1'b0, `PP_CMD_WFLASH);
    op(3'h1, 1'b0, 1'b0, 8'h12);
    op(3'h2, 1'b0, 1'b0, 8'h34);
    op(3'h2, 1'b1, 1'b0, 8'h56);
    op(3'h1, 1'b1, 1'b0, 8'h02);
    op(3'h3, 1'b0, 1'b0, 8'h00);
    op(3'h0, 1'b0, 1'b0, `PP_CMD_RFLASH);
    op(3'h1, 1'b1, 1'b0, 8'h02);
    op(3'h1, 1'b0, 1'b0, 8'h12);
    rd(1'b0, 1'b0, 8'h34);
    rd(1'b1, 1'b0, 8'h56);
    op(3'h0, 1'b0, 1'b0, `PP_CMD_WEE);
    op(3'h1, 1'b0, 1'b0, 8'h05);
    op(3'h2, 1'b0, 1'b0, 8'h9c);
    op(3'h3, 1'b0, 1'b0, 8'h00);
    op(3'h0, 1'b0, 1'b0, `PP_CMD_REE);
    rd(1'b0, 1'b0, 8'h9c);
    $display("test flash and eeprom done");
  endtask
  task automatic t_fuse_sig;
    op(3'h0, 1'b0, 1'b0, `PP_CMD_WFUSE);
    op(3'h2, 1'b0, 1'b0, 8'ha5);
    op(3'h3, 1'b0, 1'b0, 8'h00);
    op(3'h2, 1'b0, 1'b0, 8'h3c);
    op(3'h3, 1'b1, 1'b0, 8'h00);
    op(3'h0, 1'b0, 1'b0, `PP_CMD_RFUSE);
    rd(1'b0, 1'b0, 8'ha5);
    rd(1'b1, 1'b1, 8'h3c);
    op(3'h0, 1'b0, 1'b0, `PP_CMD_RSIG);
    for (int s = 0; s < 3; s++) begin
      op(3'h1, 1'b0, 1'b0, s[7:0]);
      rd(1'b0, 1'b0, SIGS[s]);
    end
    rd(1'b1, 1'b0, CAL);
    $display("test fuse and signature done");
  endtask
  task automatic t_lock;
    op(3'h0, 1'b0, 1'b0, `PP_CMD_WLOCK);
    op(3'h2, 1'b0, 1'b0, 8'hfc);
    op(3'h3, 1'b0, 1'b0, 8'h00);
    op(3'h2, 1'b0, 1'b0, 8'hff);
    op(3'h3, 1'b0, 1'b0, 8'h00);
    op(3'h0, 1'b0, 1'b0, `PP_CMD_RFUSE);
    rd(1'b1, 1'b0, 8'hfc);
    cmp(lock_bits_out, 8'hfc);
    op(3'h0, 1'b0, 1'b0, `PP_CMD_ERASE);
    op(3'h3, 1'b0, 1'b0, 8'h00);
    op(3'h0, 1'b0, 1'b0, `PP_CMD_RFUSE);
    rd(1'b1, 1'b0, `PP_LOCK_RESET);
    rd(1'b0, 1'b0, 8'ha5);
    $display("test lock done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_in);
    #1;
    rst_b_in = 1'b1;
    t_erase();
    t_flash_ee();
    t_fuse_sig();
    t_lock();
    wrap_up();
  end
  // run needs about 1700 cycles; allow several times that
  initial begin
    #200000;
    n_mismatch++;
    wrap_up();
  end
endmodule
